// file: src/rpd_ctrl.sv
// Reset sampling, power-down and wake-up sequencing with an Avalon-MM register slave
//
// Overview of operation
// - Either external interrupt, if enabled and level-sensitive, also ends power-down.
// - Interrupt wake leaves memory and registers untouched.
// - Only enabled level-sensitive sources may wake.
// - Service interrupt, then resume after power-down instruction.
// - Filtered reset pin sampled once per machine cycle.
// - Reset from second high sample, repeated until low.
// - Both strobes driven high during reset.
// - Watchdog overflow reset pulse lasts 16x2048 ticks.
// - Enabled watchdog overflow resets even with pin low.
// - Reset clears core registers except the serial buffer, stack 07, ports FF.
// - Reset loads watchdog, power and priority values.
// - Power-down bit stops oscillator, wins over idle.
// - Watchdog reset ends power-down like pin reset.
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module rpd_ctrl #(
  parameter int WD_PULSE_TICKS = rpd_pkg::WD_PULSE_TICKS,
  parameter int WD_OSC_DIV     = rpd_pkg::WD_OSC_DIV,
  parameter int WD_PRESCALE    = rpd_pkg::WD_PRESCALE,
  parameter int OSC_START_CYC  = rpd_pkg::OSC_START_CYC
) (
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  input  wire logic [rpd_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [rpd_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic [rpd_pkg::DATA_W-1:0]      avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       rst_pin,
  input  wire logic                       ext_irq_a_pin,
  input  wire logic                       ext_irq_b_pin,
  input  wire logic                       irq_ack_a,
  input  wire logic                       irq_ack_b,
  output logic                            core_reset,
  output logic                            core_run_en,
  output logic                            osc_run,
  output logic                            ale_out,
  output logic                            prog_store_strobe,
  output logic                            irq_req_a,
  output logic                            irq_req_b,
  output logic                            irq_prio_a,
  output logic                            irq_prio_b,
  output logic                            wdog_reset_out,
  output logic [31:0]                     port_out
);
  import rpd_pkg::*;

  if (OSC_START_CYC < 1 || OSC_START_CYC > 65535) begin : g_bad_start
    $error("rpd_ctrl: OSC_START_CYC out of range");
  end

  // Registered state
  rpd_state_t  state;
  logic [7:0]  power_control_reg;
  logic [7:0]  watchdog_control_reg;
  logic [7:0]  irq_cfg;
  logic [7:0]  irq_priority_reg;
  logic [7:0]  core [CORE_REGS];
  logic        ext_irq_a_flag;
  logic        ext_irq_b_flag;
  logic [1:0]  rst_cnt;
  logic [15:0] start_cnt;
  logic        wait_ack;
  logic [31:0] rdata;
  logic        wake_by_irq;
  logic        ale_q;
  logic        pse_q;
  logic [2:0]  pin_s1;
  logic [2:0]  pin_s2;
  logic [1:0]  irq_prev;

  // Next values
  rpd_state_t  next_state;
  logic [7:0]  next_power_control_reg;
  logic [7:0]  next_watchdog_control_reg;
  logic [7:0]  next_irq_cfg;
  logic [7:0]  next_irq_priority_reg;
  logic [7:0]  next_core [CORE_REGS];
  logic        next_ext_irq_a_flag;
  logic        next_ext_irq_b_flag;
  logic [1:0]  next_rst_cnt;
  logic [15:0] next_start_cnt;
  logic        next_wait_ack;
  logic [31:0] next_rdata;
  logic        next_wake_by_irq;
  logic        next_ale;
  logic        next_pse;

  // Glue
  logic        mc_stb;
  logic        wd_pulse;
  logic [7:0]  watchdog_counter;
  logic        wd_enable;
  logic        wd_kick;
  logic        rst_line;
  logic        pin_rst;
  logic        pin_a_low;
  logic        pin_b_low;
  logic        wake_a;
  logic        wake_b;
  logic        bus_wr;
  logic        in_reset;

  // True when an offset falls in the core register bank
  function automatic logic core_hit(input logic [7:0] addr);
    return addr >= OFS_CORE_BASE && addr < 8'(OFS_CORE_BASE + 4 * CORE_REGS)
           && addr[1:0] == 2'b00;
  endfunction

  // Bank index of an offset inside the core register bank
  function automatic int core_index(input logic [7:0] addr);
    return int'((addr - OFS_CORE_BASE) >> 2);
  endfunction

  // Two-flop synchronisers for the pins: reset, interrupt a, interrupt b
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pin_s1 <= 3'b110;
      pin_s2 <= 3'b110;
    end else begin
      pin_s1 <= {ext_irq_b_pin, ext_irq_a_pin, rst_pin};
      pin_s2 <= pin_s1;
    end
  end

  assign pin_rst   = pin_s2[0];
  assign pin_a_low = !pin_s2[1];
  assign pin_b_low = !pin_s2[2];

  // Watchdog pulse is or-ed in ahead of the sampler, so a low pin cannot mask it
  assign rst_line  = pin_rst || wd_pulse;
  assign in_reset  = (rst_cnt >= 2'(RST_SAMPLES));
  assign wd_enable = (watchdog_control_reg != WDOG_RESET);
  assign bus_wr    = avs_write && wait_ack && avs_byteenable[0];
  assign wd_kick   = bus_wr && avs_address == OFS_WDOG_KICK;

  // Only enabled level-sensitive sources may leave power-down
  assign wake_a = irq_cfg[CFG_A_EN_BIT] && !irq_cfg[CFG_A_EDGE_BIT] && pin_a_low;
  assign wake_b = irq_cfg[CFG_B_EN_BIT] && !irq_cfg[CFG_B_EDGE_BIT] && pin_b_low;

  rpd_mcycle_div #(
    .DIV (MCYCLE_OSC)
  ) u_div (
    .mclk   (mclk),
    .nrst   (nrst),
    .run_en (state == ST_RUN || state == ST_IDLE),
    .mc_stb (mc_stb)
  );

  rpd_wdog #(
    .OSC_DIV     (WD_OSC_DIV),
    .PRESCALE    (WD_PRESCALE),
    .PULSE_TICKS (WD_PULSE_TICKS)
  ) u_wdog (
    .mclk             (mclk),
    .nrst             (nrst),
    .enable           (wd_enable),
    .kick             (wd_kick),
    .wd_pulse         (wd_pulse),
    .watchdog_counter (watchdog_counter)
  );

  // Sequencing, flags, register file and bus answer
  always_comb begin
    next_state                = state;
    next_power_control_reg    = power_control_reg;
    next_watchdog_control_reg = watchdog_control_reg;
    next_irq_cfg              = irq_cfg;
    next_irq_priority_reg     = irq_priority_reg;
    next_core                 = core;
    next_ext_irq_a_flag       = ext_irq_a_flag;
    next_ext_irq_b_flag       = ext_irq_b_flag;
    next_rst_cnt              = rst_cnt;
    next_start_cnt            = start_cnt;
    next_wake_by_irq          = wake_by_irq;
    next_rdata                = rdata;
    next_wait_ack             = (avs_read || avs_write) && !wait_ack;

    // Reset pin sampled once per machine cycle; reset from the second high sample
    if (mc_stb) begin
      if (rst_line) begin
        next_rst_cnt = in_reset ? rst_cnt : rst_cnt + 2'b01;
      end else begin
        next_rst_cnt = 2'b00;
      end
    end

    // Flags only latch in run and idle; ack clears, a new event wins
    if (irq_ack_a) next_ext_irq_a_flag = 1'b0;
    if (irq_ack_b) next_ext_irq_b_flag = 1'b0;
    if (state == ST_RUN || state == ST_IDLE) begin
      if (irq_cfg[CFG_A_EDGE_BIT] ? (pin_a_low && irq_prev[0]) : pin_a_low) begin
        next_ext_irq_a_flag = 1'b1;
      end
      if (irq_cfg[CFG_B_EDGE_BIT] ? (pin_b_low && irq_prev[1]) : pin_b_low) begin
        next_ext_irq_b_flag = 1'b1;
      end
    end

    // Bus read data is captured in the wait cycle and stands for the answer cycle
    if (avs_read && !wait_ack) begin
      next_rdata = 32'h0;
      if (core_hit(avs_address)) begin
        next_rdata[7:0] = core[core_index(avs_address)];
      end else begin
        case (avs_address)
          OFS_POWER_CTRL: next_rdata[7:0] = power_control_reg;
          OFS_WDOG_CTRL:  next_rdata[7:0] = watchdog_control_reg;
          OFS_IRQ_CFG:    next_rdata[7:0] = irq_cfg;
          OFS_IRQ_PRIO:   next_rdata[7:0] = irq_priority_reg;
          OFS_STATUS:     next_rdata[15:0] = {watchdog_counter, wake_by_irq, wd_pulse,
                                              in_reset, ext_irq_b_flag, ext_irq_a_flag,
                                              1'b0, state};
          default:        next_rdata = 32'h0;
        endcase
      end
    end

    // Register writes take effect at the edge that ends the answer cycle
    if (bus_wr) begin
      if (core_hit(avs_address)) begin
        next_core[core_index(avs_address)] = avs_writedata[7:0];
      end else begin
        case (avs_address)
          OFS_POWER_CTRL: next_power_control_reg = avs_writedata[7:0] & PWR_WMASK;
          OFS_WDOG_CTRL:  next_watchdog_control_reg = avs_writedata[7:0];
          OFS_IRQ_CFG:    next_irq_cfg = avs_writedata[7:0] & CFG_WMASK;
          OFS_IRQ_PRIO:   next_irq_priority_reg = avs_writedata[7:0] & PRIO_WMASK;
          default:        next_irq_cfg = next_irq_cfg;
        endcase
      end
    end

    // Power states
    case (state)
      ST_RUN: begin
        if (bus_wr && avs_address == OFS_POWER_CTRL) begin
          if (avs_writedata[PWR_PD_BIT]) begin
            next_state = ST_PDOWN;
          end else if (avs_writedata[PWR_IDL_BIT]) begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (irq_req_a || irq_req_b) begin
          next_power_control_reg[PWR_IDL_BIT] = 1'b0;
          next_state = ST_RUN;
        end
      end
      ST_PDOWN: begin
        // Oscillator frozen: only reset or a level wake restarts it
        next_start_cnt = 16'(OSC_START_CYC);
        if (rst_line) begin
          next_wake_by_irq = 1'b0;
          next_state       = ST_WAKE;
        end else if (wake_a || wake_b) begin
          next_wake_by_irq = 1'b1;
          next_state       = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // The waking source keeps its input low through the start-up wait
        if (start_cnt > 16'h0001) begin
          next_start_cnt = start_cnt - 16'h0001;
        end else begin
          // Only the mode bit drops; the pending level flag is serviced first
          next_power_control_reg[PWR_PD_BIT] = 1'b0;
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase

    // Internal reset loads the documented values and overrides the state, flags and register file above, bar the serial buffer
    if (in_reset) begin
      next_state                = ST_RUN;
      next_power_control_reg    = PWR_RESET;
      next_watchdog_control_reg = WDOG_RESET;
      next_irq_priority_reg     = PRIO_RESET;
      next_irq_cfg              = CFG_RESET;
      next_ext_irq_a_flag       = 1'b0;
      next_ext_irq_b_flag       = 1'b0;
      next_wake_by_irq          = 1'b0;
      for (int i = 0; i < CORE_REGS; i++) begin
        if (i != IDX_SERIAL_BUFFER) next_core[i] = rpd_core_reset_value(i);
      end
    end

    // Strobe pins: high in reset and idle, low in power-down
    next_ale = 1'b0;
    next_pse = 1'b1;
    if (next_rst_cnt >= 2'(RST_SAMPLES)) begin
      next_ale = 1'b1;
      next_pse = 1'b1;
    end else if (next_state == ST_IDLE) begin
      next_ale = 1'b1;
    end else if (next_state == ST_PDOWN || next_state == ST_WAKE) begin
      next_pse = 1'b0;
    end else begin
      next_ale = mc_stb;
    end
  end

  // Register the whole group; after power-up the core stays in reset until the pin is low
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state                <= ST_RUN;
      power_control_reg    <= PWR_RESET;
      watchdog_control_reg <= WDOG_RESET;
      irq_cfg              <= CFG_RESET;
      irq_priority_reg     <= PRIO_RESET;
      for (int i = 0; i < CORE_REGS; i++) core[i] <= 8'h00;
      ext_irq_a_flag       <= 1'b0;
      ext_irq_b_flag       <= 1'b0;
      rst_cnt              <= 2'(RST_SAMPLES);
      start_cnt            <= 16'h0000;
      wait_ack             <= 1'b0;
      rdata                <= 32'h0;
      wake_by_irq          <= 1'b0;
      ale_q                <= 1'b1;
      pse_q                <= 1'b1;
      irq_prev             <= 2'b11; // Pins idle high, so no false edge after reset
    end else begin
      state                <= next_state;
      power_control_reg    <= next_power_control_reg;
      watchdog_control_reg <= next_watchdog_control_reg;
      irq_cfg              <= next_irq_cfg;
      irq_priority_reg     <= next_irq_priority_reg;
      core                 <= next_core;
      ext_irq_a_flag       <= next_ext_irq_a_flag;
      ext_irq_b_flag       <= next_ext_irq_b_flag;
      rst_cnt              <= next_rst_cnt;
      start_cnt            <= next_start_cnt;
      wait_ack             <= next_wait_ack;
      rdata                <= next_rdata;
      wake_by_irq          <= next_wake_by_irq;
      ale_q                <= next_ale;
      pse_q                <= next_pse;
      irq_prev             <= {!pin_b_low, !pin_a_low};
    end
  end

  // Outputs
  assign avs_waitrequest   = (avs_read || avs_write) && !wait_ack;
  assign avs_readdata      = rdata;
  assign core_reset        = in_reset;
  assign core_run_en       = (state == ST_RUN) && !in_reset;
  assign osc_run           = (state != ST_PDOWN);
  assign ale_out           = ale_q;
  assign prog_store_strobe = pse_q;
  assign irq_req_a         = ext_irq_a_flag && irq_cfg[CFG_A_EN_BIT];
  assign irq_req_b         = ext_irq_b_flag && irq_cfg[CFG_B_EN_BIT];
  assign irq_prio_a        = irq_priority_reg[PRIO_A_BIT];
  assign irq_prio_b        = irq_priority_reg[PRIO_B_BIT];
  assign wdog_reset_out    = wd_pulse;
  assign port_out          = {core[IDX_P3], core[IDX_P3-1], core[IDX_P0+1], core[IDX_P0]};
endmodule // rpd_ctrl

// file: src/rpd_pkg.sv
// Package: register map, field layout, reset values and timing for the reset and wake-up block
package rpd_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_POWER_CTRL  = 8'h00;
  localparam logic [7:0] OFS_WDOG_CTRL   = 8'h04;
  localparam logic [7:0] OFS_IRQ_CFG     = 8'h08;
  localparam logic [7:0] OFS_IRQ_PRIO    = 8'h0c;
  localparam logic [7:0] OFS_STATUS      = 8'h10;
  localparam logic [7:0] OFS_WDOG_KICK   = 8'h14;
  localparam logic [7:0] OFS_CORE_BASE   = 8'h40;

  // Power control fields
  localparam int         PWR_IDL_BIT     = 0;
  localparam int         PWR_PD_BIT      = 1;
  localparam logic [7:0] PWR_WMASK       = 8'h8f;
  localparam logic [7:0] PWR_RESET       = 8'h00;

  // Interrupt configuration fields
  localparam int         CFG_A_EN_BIT    = 0;
  localparam int         CFG_A_EDGE_BIT  = 1;
  localparam int         CFG_B_EN_BIT    = 2;
  localparam int         CFG_B_EDGE_BIT  = 3;
  localparam logic [7:0] CFG_WMASK       = 8'h0f;
  localparam logic [7:0] CFG_RESET       = 8'h00;

  // Priority register fields
  localparam int         PRIO_A_BIT      = 0;
  localparam int         PRIO_B_BIT      = 2;
  localparam logic [7:0] PRIO_WMASK      = 8'h7f;
  localparam logic [7:0] PRIO_RESET      = 8'h00;

  // Watchdog control: this value keeps the watchdog stopped
  localparam logic [7:0] WDOG_RESET      = 8'ha5;

  // Core register bank indices
  localparam int         CORE_REGS       = 18;
  localparam int         IDX_SP          = 7;
  localparam int         IDX_P0          = 13;
  localparam int         IDX_P3          = 16;
  localparam int         IDX_SERIAL_BUFFER        = 17;
  localparam logic [7:0] SP_RESET        = 8'h07;
  localparam logic [7:0] PORT_RESET      = 8'hff;
  localparam logic [7:0] ZERO_RESET      = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MCYCLE_OSC     = 12;
  localparam int RST_SAMPLES    = 2;
  localparam int OSC_START_NS   = 10000;
  localparam int OSC_START_CYC  = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_PULSE_MULT  = 16;
  localparam int WD_PULSE_BASE  = 2048;
  localparam int WD_PULSE_TICKS = WD_PULSE_MULT * WD_PULSE_BASE;
  localparam int WD_OSC_DIV     = 8;
  localparam int WD_PRESCALE    = 64;

  typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_PDOWN, ST_WAKE} rpd_state_t;

  // Reset value of one core register
  function automatic logic [7:0] rpd_core_reset_value(input int idx);
    if (idx == IDX_SP) return SP_RESET;
    if (idx >= IDX_P0 && idx <= IDX_P3) return PORT_RESET;
    return ZERO_RESET;
  endfunction

endpackage

// file: src/rpd_mcycle_div.sv
// Machine-cycle strobe divider, frozen while the oscillator is stopped
`timescale 1ns/1ps
module rpd_mcycle_div #(
  parameter int DIV = rpd_pkg::MCYCLE_OSC
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic run_en,
  output logic      mc_stb
);
  import rpd_pkg::*;

  logic [7:0] cnt;
  logic [7:0] next_cnt;

  if (DIV < 2 || DIV > 255) begin : g_bad_div
    $error("rpd_mcycle_div: DIV out of range");
  end

  // Count oscillator periods; hold when the oscillator is frozen
  always_comb begin
    next_cnt = cnt;
    if (run_en) begin
      next_cnt = (cnt == 8'(DIV - 1)) ? 8'h00 : cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt    <= 8'h00;
      mc_stb <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      mc_stb <= run_en && (cnt == 8'(DIV - 1));
    end
  end
endmodule // rpd_mcycle_div

// file: src/rpd_wdog.sv
// Watchdog unit: own slow tick, overflow counter and stretched reset pulse
`timescale 1ns/1ps
module rpd_wdog #(
  parameter int OSC_DIV     = rpd_pkg::WD_OSC_DIV,
  parameter int PRESCALE    = rpd_pkg::WD_PRESCALE,
  parameter int PULSE_TICKS = rpd_pkg::WD_PULSE_TICKS
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       enable,
  input  wire logic       kick,
  output logic            wd_pulse,
  output logic [7:0]      watchdog_counter
);
  import rpd_pkg::*;

  logic [15:0] osc_cnt;
  logic [15:0] pre_cnt;
  logic [31:0] pulse_cnt;
  logic [15:0] next_osc_cnt;
  logic [15:0] next_pre_cnt;
  logic [31:0] next_pulse_cnt;
  logic [7:0]  next_counter;
  logic        tick;

  if (OSC_DIV < 1 || PRESCALE < 1 || PULSE_TICKS < 1) begin : g_bad_par
    $error("rpd_wdog: divider or pulse length must be positive");
  end

  // The watchdog oscillator keeps running in power-down, so this never stops
  assign tick = (osc_cnt == 16'(OSC_DIV - 1));

  always_comb begin
    next_osc_cnt   = tick ? 16'h0000 : osc_cnt + 16'h0001;
    next_pre_cnt   = pre_cnt;
    next_counter   = watchdog_counter;
    next_pulse_cnt = pulse_cnt;
    if (tick && pulse_cnt != 32'h0) begin
      next_pulse_cnt = pulse_cnt - 32'h1;
    end
    if (kick || !enable) begin
      next_pre_cnt = 16'h0000;
      next_counter = 8'h00;
    end else if (tick) begin
      next_pre_cnt = (pre_cnt == 16'(PRESCALE - 1)) ? 16'h0000 : pre_cnt + 16'h0001;
      if (pre_cnt == 16'(PRESCALE - 1)) begin
        next_counter = watchdog_counter + 8'h01;
        if (watchdog_counter == 8'hff) begin
          next_pulse_cnt = 32'(PULSE_TICKS);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      osc_cnt          <= 16'h0000;
      pre_cnt          <= 16'h0000;
      pulse_cnt        <= 32'h0;
      watchdog_counter <= 8'h00;
    end else begin
      osc_cnt          <= next_osc_cnt;
      pre_cnt          <= next_pre_cnt;
      pulse_cnt        <= next_pulse_cnt;
      watchdog_counter <= next_counter;
    end
  end

  // Pulse drives the internal reset line high until the count runs out
  assign wd_pulse = (pulse_cnt != 32'h0);
endmodule // rpd_wdog

// file: sim/rpd_ctrl_chk.sv
// Checker: port timing relations of the reset and wake-up block
`timescale 1ns/1ps
module rpd_ctrl_chk #(
  parameter int WD_PULSE_TICKS = 16,
  parameter int WD_OSC_DIV     = 2
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic rst_pin,
  input wire logic ext_irq_a_pin,
  input wire logic ext_irq_b_pin,
  input wire logic core_reset,
  input wire logic core_run_en,
  input wire logic osc_run,
  input wire logic ale_out,
  input wire logic prog_store_strobe,
  input wire logic wdog_reset_out
);
  localparam int WD_LO = (WD_PULSE_TICKS - 1) * WD_OSC_DIV;
  localparam int WD_HI = (WD_PULSE_TICKS + 1) * WD_OSC_DIV;
  logic [15:0] wd_len;
  logic [15:0] next_wd_len;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Length of the current watchdog pulse in mclk cycles
  always_comb begin
    next_wd_len = wdog_reset_out ? wd_len + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge mclk) begin
    wd_len <= nrst ? next_wd_len : 16'h0000;
  end
  // Run span of one machine cycle after an address strobe
  sequence run_mcycle;
    $rose(ale_out) && core_run_en && $past(core_run_en) ##1 core_run_en [*8] ##1 core_run_en [*3];
  endsequence
  chk_rst_strobes: assert property (core_reset && $past(core_reset) |-> ale_out && prog_store_strobe)
    else $error("strobes low during reset");
  chk_rst_halts: assert property (core_reset |-> !core_run_en)
    else $error("core runs during reset");
  chk_rst_cause: assert property ($rose(core_reset) |-> $past(rst_pin || wdog_reset_out, 12))
    else $error("reset without two high samples");
  chk_rst_release: assert property ($fell(core_reset) |-> !rst_pin && !wdog_reset_out && !$past(rst_pin, 2))
    else $error("reset dropped with line high");
  chk_pd_quiet: assert property (!osc_run && $past(!osc_run) |-> !ale_out && !prog_store_strobe && !core_run_en)
    else $error("activity in power-down");
  chk_ale_period: assert property (run_mcycle |=> ale_out || !core_run_en)
    else $error("strobe period not twelve");
  chk_ale_pulse: assert property ($rose(ale_out) && core_run_en |=> !ale_out || !core_run_en)
    else $error("strobe wider than one cycle");
  chk_wdog_force: assert property ($rose(wdog_reset_out) |-> ##[1:60] core_reset)
    else $error("watchdog pulse gave no reset");
  chk_wdog_width: assert property ($fell(wdog_reset_out) |-> wd_len >= WD_LO && wd_len <= WD_HI)
    else $error("watchdog pulse length wrong");
  chk_wake_cause: assert property ($rose(osc_run) |-> !ext_irq_a_pin || !ext_irq_b_pin || rst_pin || wdog_reset_out)
    else $error("wake without cause");
endmodule // rpd_ctrl_chk

bind rpd_ctrl rpd_ctrl_chk #(.WD_PULSE_TICKS(WD_PULSE_TICKS), .WD_OSC_DIV(WD_OSC_DIV)) u_chk (
  .mclk(mclk), .nrst(nrst), .rst_pin(rst_pin), .ext_irq_a_pin(ext_irq_a_pin),
  .ext_irq_b_pin(ext_irq_b_pin), .core_reset(core_reset), .core_run_en(core_run_en),
  .osc_run(osc_run), .ale_out(ale_out), .prog_store_strobe(prog_store_strobe),
  .wdog_reset_out(wdog_reset_out));

// file: sim/rpd_ext_src.sv
// Far side model: reset circuit and the two external interrupt sources
`timescale 1ns/1ps
module rpd_ext_src #(
  parameter int HOLD = 26
) (
  input  wire logic mclk,
  input  wire logic rst_req,
  input  wire logic rst_glitch,
  input  wire logic a_low,
  input  wire logic b_low,
  output logic      rst_pin,
  output logic      ext_irq_a_pin,
  output logic      ext_irq_b_pin
);
  logic [7:0] hold_cnt = 8'h00;
  logic [7:0] next_hold_cnt;
  // A request stretches the pin past two machine cycles plus sync slack
  always_comb begin
    next_hold_cnt = (hold_cnt != 8'h00) ? hold_cnt - 8'h01 : 8'h00;
    if (rst_req) next_hold_cnt = 8'(HOLD);
  end
  always_ff @(posedge mclk) begin
    hold_cnt <= next_hold_cnt;
  end
  // Glitch input breaks the minimum width on purpose
  assign rst_pin = rst_req || (hold_cnt != 8'h00) || rst_glitch;
  assign ext_irq_a_pin = !a_low;
  assign ext_irq_b_pin = !b_low;
endmodule // rpd_ext_src

// file: sim/tb_rpd_ctrl.sv
// Testbench: reset values, reset sampling, power-down wake and watchdog reset
`timescale 1ns/1ps
module tb_rpd_ctrl;
  import rpd_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic irq_ack_a = 1'b0, irq_ack_b = 1'b0, rq = 1'b1, gl = 1'b0, al = 1'b0, bl = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, port_out, rdat;
  logic avs_waitrequest, rst_pin, ext_irq_a_pin, ext_irq_b_pin, core_reset, core_run_en;
  logic osc_run, ale_out, prog_store_strobe, irq_req_a, irq_req_b, irq_prio_a, irq_prio_b;
  logic wdog_reset_out;
  int n_fail = 0, checks_done = 0;
  localparam logic [7:0] RA [10] = '{OFS_POWER_CTRL, OFS_WDOG_CTRL, OFS_IRQ_PRIO, 8'h40,
    8'h44, 8'h5c, 8'h70, 8'h74, 8'h80, 8'h30};
  localparam logic [7:0] RE [10] = '{PWR_RESET, WDOG_RESET, PRIO_RESET, 8'h00, 8'h00,
    SP_RESET, 8'h00, PORT_RESET, PORT_RESET, 8'h00};
  rpd_ctrl #(.WD_PULSE_TICKS(16), .WD_OSC_DIV(2), .WD_PRESCALE(1), .OSC_START_CYC(4)) dut (.*);
  rpd_ext_src u_src (.mclk(mclk), .rst_req(rq), .rst_glitch(gl), .a_low(al), .b_low(bl),
    .rst_pin(rst_pin), .ext_irq_a_pin(ext_irq_a_pin), .ext_irq_b_pin(ext_irq_b_pin));
  always #5 mclk = ~mclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return osc_run;
      1: return core_reset;
      default: return core_run_en;
    endcase
  endfunction
  // Bounded wait for a status output to reach a level
  task automatic await(input int s, input logic v);
    int n;
    n = 0;
    while (sig(s) !== v && n < 900) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 900) n_fail++;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (40) @(posedge mclk);
    rq <= 1'b0;
    await(1, 1'b0);
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, RA[i], 32'h0);
      chk(rdat, {24'h0, RE[i]});
    end
    $display("reset value table done");
    // A pulse shorter than one machine cycle is one sample at most
    bus(1'b1, 8'h40, 32'h5a);
    gl <= 1'b1;
    repeat (6) @(posedge mclk);
    gl <= 1'b0;
    repeat (30) @(posedge mclk);
    chk(core_reset, 1'b0);
    rq <= 1'b1;
    @(posedge mclk);
    rq <= 1'b0;
    await(1, 1'b1);
    repeat (2) @(posedge mclk);
    chk({core_reset, ale_out, prog_store_strobe}, 3'h7);
    await(1, 1'b0);
    bus(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h0);
    $display("reset pin test done");
    // Edge source b must not wake; level source a must
    bus(1'b1, OFS_IRQ_CFG, 32'h0d);
    bus(1'b1, OFS_IRQ_PRIO, 32'h01);
    @(posedge mclk);
    chk({irq_prio_b, irq_prio_a}, 2'h1);
    bus(1'b1, 8'h78, 32'h3c);
    bus(1'b1, OFS_POWER_CTRL, 32'h03);
    repeat (3) @(posedge mclk);
    chk({osc_run, ale_out, prog_store_strobe}, 3'h0);
    bl <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(osc_run, 1'b0);
    bl <= 1'b0;
    repeat (3) @(posedge mclk);
    al <= 1'b1;
    await(2, 1'b1);
    repeat (3) @(posedge mclk);
    chk({irq_req_b, irq_req_a}, 2'h1);
    chk(port_out[15:8], 8'h3c);
    al <= 1'b0;
    repeat (3) @(posedge mclk);
    irq_ack_a <= 1'b1;
    @(posedge mclk);
    irq_ack_a <= 1'b0;
    bus(1'b0, OFS_POWER_CTRL, 32'h0);
    chk({irq_req_a, rdat[1]}, 2'h0);
    $display("wake test done");
    // Idle keeps both strobes high; an enabled interrupt ends it
    bus(1'b1, OFS_POWER_CTRL, 32'h01);
    repeat (3) @(posedge mclk);
    chk({ale_out, prog_store_strobe, core_run_en}, 3'h6);
    al <= 1'b1;
    await(2, 1'b1);
    chk(irq_req_a, 1'b1);
    al <= 1'b0;
    repeat (3) @(posedge mclk);
    irq_ack_a <= 1'b1;
    @(posedge mclk);
    irq_ack_a <= 1'b0;
    $display("idle test done");
    // Watchdog overflow while powered down resets with the pin low
    bus(1'b1, OFS_WDOG_CTRL, 32'h00);
    bus(1'b1, OFS_POWER_CTRL, 32'h02);
    await(1, 1'b1);
    chk({core_reset, rst_pin}, 2'h2);
    await(1, 1'b0);
    chk(osc_run, 1'b1);
    bus(1'b0, OFS_WDOG_CTRL, 32'h0);
    chk(rdat, {24'h0, WDOG_RESET});
    $display("watchdog test done");
    print_verdict;
  end
endmodule // tb_rpd_ctrl
